// >>> msc_cfg.svh
/*
  constants of the module serial configuration port: widths, field
  positions, reset values and timing figures shared by both ends.
  assumes it is included by bare name, after the package, by each end.
*/
`ifndef MSC_CFG_SVH
`define MSC_CFG_SVH

// slot-select number length, in bits
`define MSC_SLOT_W      16
// identification register length, in bits
`define MSC_ID_W        32
// configuration register length, in bits
`define MSC_CFG_W       16
// last channel counter code: channels 0..7 then the temperature sensor
`define MSC_CHAN_LAST   4'h8
// channel counter value after reset
`define MSC_CHAN_RST    4'h0
// slot-select shifter value after reset
`define MSC_SLOT_RST    16'h0000
// system clock period, ns
`define MSC_CLK_NS      25
// least time each half of a serial or scan clock pulse is held, ns
`define MSC_HALF_NS     200
// positions of the link inputs inside the device's synchroniser vector
`define MSC_IX_SCLK     0
`define MSC_IX_CSN      1
`define MSC_IX_DAI      2
`define MSC_IX_SIN      3
`define MSC_IX_SCAN     4
`define MSC_IX_W        5
// synchroniser reset: idle levels, clock, select and indicator high
`define MSC_SYNC_IDLE   5'h07

`endif

// >>> msc_pkg.sv
/*
  types of the module serial configuration port: host command codes
  and host sequencer states.
  assumes nothing beyond a SystemVerilog compiler.
*/
package msc_pkg;

  // host commands
  typedef enum logic [1:0] {
    MSC_OP_SELECT,  // shift a slot-select number to the chassis controller
    MSC_OP_WRITE,   // write the module configuration register
    MSC_OP_READ,    // read the module identification register
    MSC_OP_END      // drop the chassis-controller select, ending a session
  } msc_op_t;

  // host sequencer states
  typedef enum logic [2:0] {
    MSC_ST_IDLE,
    MSC_ST_CS_DROP,
    MSC_ST_BIT_SETUP,
    MSC_ST_BIT_LOW,
    MSC_ST_BIT_HIGH,
    MSC_ST_CS_RAISE,
    MSC_ST_DONE
  } msc_host_state_t;

endpackage

// >>> msc_link_if.sv
/*
  the serial link between the acquisition controller (host end) and the
  module with its chassis controller (module end).
  assumes the testbench instantiates it and connects both ends.
*/
`timescale 1ns/1ps
interface msc_link_if;
  logic serial_in_line;         // host to module serial data
  logic serial_out_line;        // module to host serial data
  logic data_addr_indicator;    // low data, high address/identification
  logic chassis_ctrl_select_n;  // low: stream goes to chassis controller
  logic serial_shift_clock;     // serial clock, made by the host
  logic scan_step_clock;        // advances the channel counter

  modport host_end (
    output serial_in_line,
    output data_addr_indicator,
    output chassis_ctrl_select_n,
    output serial_shift_clock,
    output scan_step_clock,
    input  serial_out_line
  );

  modport module_end (
    input  serial_in_line,
    input  data_addr_indicator,
    input  chassis_ctrl_select_n,
    input  serial_shift_clock,
    input  scan_step_clock,
    output serial_out_line
  );
endinterface

// >>> msc_module_end.sv
/*
  module end of the serial configuration port: chassis-controller slot
  select shifter, module select, configuration register, identification
  shifter and channel step counter.
  assumes every link line is asynchronous to clock and is sampled through
  two flip-flops; the serial clock must stay in each level for at least
  four system clock periods so that every edge is seen.
  a read bit shows three edges after the pin's rise; the
  master samples half a period later, never at the rise.
  keep SELECT_CODE non-zero: slot zero means nobody.
  the id shifter runs only while selected.
*/
`timescale 1ns/1ps
`include "msc_cfg.svh"

// Function
// - indicator low means data, high identification/address
// - select low feeds controller, high the module
// - serial input sampled on rising serial clock
// - scan clock rising edge advances channel counter
// - master starts slot select with lines high; the host leaves select low after an end and the indicator low after a write
// - select falling deasserts every module select
// - slot bits sent MSB first, low-high clock
// - select rising asserts only the addressed module
// - master writes zero slot when idle
// - identification reloaded while module select deasserted
// - zeros after all 32 identification bits
// - write: indicator low, clock pulses per bit
// - read: indicator stays high throughout
// - each clock pulse presents the next bit
// - master ends session by dropping select
// - counter picks eight channels then temperature sensor
module msc_module_end #(
  parameter logic [`MSC_SLOT_W-1:0] SELECT_CODE = 16'h0001,       // slot number that picks us
  parameter logic [`MSC_ID_W-1:0]   MODULE_ID   = 32'hA5C3_0001,  // arbitrary value
  parameter int                     CFG_W       = `MSC_CFG_W      // configuration width
) (
  input  wire logic             clock,
  input  wire logic             rst,
  msc_link_if.module_end        link,
  output logic                  module_selected,
  output logic [CFG_W-1:0]      config_value,
  output logic [3:0]            channel_step_counter
);

  // raw link inputs gathered into one vector for the synchroniser
  logic [`MSC_IX_W-1:0] raw_in;
  // first synchroniser stage, read only by the second
  logic [`MSC_IX_W-1:0] meta_r;
  // second synchroniser stage, the only view logic has of the link
  logic [`MSC_IX_W-1:0] sync_r;
  // one more stage to find edges
  logic [`MSC_IX_W-1:0] prev_r;

  // edge strobes and synchronised levels
  logic                   sclk_rise;     // serial clock rising edge seen
  logic                   csn_fall;      // controller select falling
  logic                   csn_rise;      // controller select rising
  logic                   scan_rise;     // scan clock rising edge seen
  logic                   to_module;     // stream routed to this module
  logic                   sin_bit;       // synchronised serial data
  logic                   dai_bit;       // synchronised indicator

  // state kept by the module end
  logic [`MSC_SLOT_W-1:0] slot_shift_r;  // chassis controller slot register
  logic                   sel_r;         // module select line
  logic [CFG_W-1:0]       cfg_r;         // configuration register
  logic [`MSC_ID_W-1:0]   id_r;          // identification shifter
  logic                   out_r;         // serial output flop
  logic [3:0]             chan_r;        // channel step counter

  // one vector, so one process syncs every line
  assign raw_in[`MSC_IX_SCLK] = link.serial_shift_clock;
  assign raw_in[`MSC_IX_CSN]  = link.chassis_ctrl_select_n;
  assign raw_in[`MSC_IX_DAI]  = link.data_addr_indicator;
  assign raw_in[`MSC_IX_SIN]  = link.serial_in_line;
  assign raw_in[`MSC_IX_SCAN] = link.scan_step_clock;

  // two-flop synchroniser plus edge history; data and clock share the
  // same delay, so the data bit seen with an edge is the one set before it
  // stages reset to the lines' idle levels: all-zero stages
  // would show a false rise of clock and select after reset
  // two stages suit lines that hold 200 ns or more
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      meta_r <= `MSC_SYNC_IDLE;
      sync_r <= `MSC_SYNC_IDLE;
      prev_r <= `MSC_SYNC_IDLE;
    end else begin
      meta_r <= raw_in;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  // rising edge of one synchronised line
  // shared by serial clock, select and scan clock
  function automatic logic rise_of(input logic now_v, input logic old_v);
    return now_v & ~old_v;
  endfunction

  // edge detection works only on the second stage and its history
  // each strobe lasts exactly one system clock
  assign sclk_rise = rise_of(sync_r[`MSC_IX_SCLK], prev_r[`MSC_IX_SCLK]);
  // falling select opens every slot select that does not follow an end command
  assign csn_fall  = ~sync_r[`MSC_IX_CSN] & prev_r[`MSC_IX_CSN];
  assign csn_rise  = rise_of(sync_r[`MSC_IX_CSN], prev_r[`MSC_IX_CSN]);
  assign scan_rise = rise_of(sync_r[`MSC_IX_SCAN], prev_r[`MSC_IX_SCAN]);
  assign sin_bit   = sync_r[`MSC_IX_SIN];
  assign dai_bit   = sync_r[`MSC_IX_DAI];

  // routing by select
  // while the controller select is low nothing reaches the module, even
  // if it is still selected from before
  // this also covers the cycle before sel_r drops
  // and keeps slot bits out of the module registers
  assign to_module = sel_r & sync_r[`MSC_IX_CSN];

  // chassis controller slot register
  // never cleared by the link: the next slot select
  // overwrites all 16 bits, and only the last 16 count
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      slot_shift_r <= `MSC_SLOT_RST;
    end else if (!sync_r[`MSC_IX_CSN] && sclk_rise) begin
      // shifts only while select is low
      // MSB first shift
      slot_shift_r <= {slot_shift_r[`MSC_SLOT_W-2:0], sin_bit};
    end
  end

  // module select line
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sel_r <= 1'b0;
    end else if (csn_fall) begin
      // every module drops out, whatever its slot
      // drop all selects
      sel_r <= 1'b0;
    end else if (csn_rise) begin
      // match written slot
      // a zero slot number picks nobody, which keeps idle writes harmless
      // decided once per rising select
      sel_r <= (slot_shift_r == SELECT_CODE);
    end
  end

  // configuration register
  // kept across reads and deselects
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cfg_r <= '0;
    end else if (to_module && sclk_rise && !dai_bit) begin
      // shift one bit per pulse
      // a read that lets the indicator fall lands here too; the master
      // must keep the indicator high for the whole of a read
      // no length check: longer bursts keep the last CFG_W bits
      cfg_r <= {cfg_r[CFG_W-2:0], sin_bit};
    end
  end

  // identification shifter and serial output
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      id_r  <= '0;
      out_r <= 1'b0;
    end else if (!sel_r) begin
      // continuous, so a cut read restarts from the top
      // reload while deselected
      id_r  <= MODULE_ID;
      out_r <= 1'b0;
    end else if (to_module && sclk_rise && dai_bit) begin
      // out_r trails id_r: pulse one brings out bit 31
      // MSB first after rising edge
      out_r <= id_r[`MSC_ID_W-1];
      // zeros fill in behind
      // after 32 pulses only the shifted-in zeros remain
      id_r  <= {id_r[`MSC_ID_W-2:0], 1'b0};
    end
  end

  // channel step counter
  // only rst and the wrap after code 8 clear it; the link cannot set a channel
  // scan levels shorter than two clocks may be missed
  // code 8 is the temperature sensor
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      chan_r <= `MSC_CHAN_RST;
    end else if (scan_rise) begin
      chan_r <= (chan_r == `MSC_CHAN_LAST) ? `MSC_CHAN_RST : chan_r + 4'h1;
    end
  end

  // every user-side output comes straight from a flop
  // the serial output idles low while deselected, so
  // a shared line sees nothing from an idle module
  // and a host sampling late reads zeros, not noise
  assign link.serial_out_line = out_r;
  assign module_selected      = sel_r;
  assign config_value         = cfg_r;
  assign channel_step_counter = chan_r;

endmodule // msc_module_end

// >>> msc_host_end.sv
/*
  host end of the serial configuration port: the acquisition controller
  that selects a slot, writes configuration, reads identification and
  emits scan clock pulses. the serial clock is made here by a divider.
  assumes one command at a time through a valid/ready handshake.
*/
`timescale 1ns/1ps
`include "msc_cfg.svh"

module msc_host_end #(
  parameter int CFG_W = `MSC_CFG_W  // configuration width in bits
) (
  input  wire logic             clock,
  input  wire logic             rst,
  msc_link_if.host_end          link,
  input  wire logic             cmd_valid,
  output logic                  cmd_ready,
  input  msc_pkg::msc_op_t      cmd_op,
  input  wire logic [31:0]      cmd_data,
  output logic                  rsp_valid,
  output logic [31:0]           rsp_data,
  input  wire logic             scan_req,
  output logic                  scan_ready
);

  // half period of generated clocks, least time rounded up
  localparam int HALF_CYC = (`MSC_HALF_NS + `MSC_CLK_NS - 1) / `MSC_CLK_NS;
  localparam logic [7:0] HALF_LD = 8'(HALF_CYC - 1);
  localparam logic [8:0] SCAN_LD = 9'(2 * HALF_CYC);

  msc_pkg::msc_host_state_t st_r;     // sequencer state
  msc_pkg::msc_op_t         op_r;     // command in progress
  logic [7:0]               timer_r;  // half period countdown
  logic [5:0]               bits_r;   // bits still to send
  logic [31:0]              tx_r;     // outgoing bits, MSB first
  logic [31:0]              rx_r;     // identification bits gathered
  logic                     sin_r;
  logic                     dai_r;
  logic                     csn_r;
  logic                     sclk_r;
  logic                     scan_r;
  logic [8:0]               scan_cnt_r;
  logic                     so_meta_r;  // first stage, feeds only so_sync_r
  logic                     so_sync_r;
  logic                     rsp_r;

  assign cmd_ready = (st_r == msc_pkg::MSC_ST_IDLE);

  // serial output from the module crosses into our clock
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      so_meta_r <= 1'b0;
      so_sync_r <= 1'b0;
    end else begin
      so_meta_r <= link.serial_out_line;
      so_sync_r <= so_meta_r;
    end
  end

  // transfer sequencer
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_r    <= msc_pkg::MSC_ST_IDLE;
      op_r    <= msc_pkg::MSC_OP_END;
      timer_r <= 8'h00;
      bits_r  <= 6'h00;
      tx_r    <= 32'h0000_0000;
      rx_r    <= 32'h0000_0000;
      sin_r   <= 1'b0;
      dai_r   <= 1'b1;
      csn_r   <= 1'b1;
      sclk_r  <= 1'b1;
      rsp_r   <= 1'b0;
    end else begin
      rsp_r <= 1'b0;
      unique case (st_r)
        msc_pkg::MSC_ST_IDLE: begin
          timer_r <= HALF_LD;
          if (cmd_valid) begin
            op_r <= cmd_op;
            rx_r <= 32'h0000_0000;
            unique case (cmd_op)
              msc_pkg::MSC_OP_SELECT: begin
                csn_r  <= 1'b0;
                tx_r   <= {cmd_data[`MSC_SLOT_W-1:0], 16'h0000};
                bits_r <= 6'(`MSC_SLOT_W);
                st_r   <= msc_pkg::MSC_ST_CS_DROP;
              end
              msc_pkg::MSC_OP_WRITE: begin
                dai_r  <= 1'b0;
                tx_r   <= cmd_data << (32 - CFG_W);
                bits_r <= 6'(CFG_W);
                st_r   <= msc_pkg::MSC_ST_BIT_SETUP;
              end
              msc_pkg::MSC_OP_READ: begin
                dai_r  <= 1'b1;
                tx_r   <= 32'h0000_0000;
                bits_r <= 6'(`MSC_ID_W);
                st_r   <= msc_pkg::MSC_ST_BIT_SETUP;
              end
              msc_pkg::MSC_OP_END: begin
                csn_r  <= 1'b0;
                bits_r <= 6'h00;
                st_r   <= msc_pkg::MSC_ST_CS_DROP;
              end
            endcase
          end
        end
        msc_pkg::MSC_ST_CS_DROP: begin
          // hold select low a half period before any clocking
          if (timer_r != 8'h00) begin
            timer_r <= timer_r - 8'h01;
          end else begin
            timer_r <= HALF_LD;
            st_r    <= (bits_r == 6'h00) ? msc_pkg::MSC_ST_DONE
                                         : msc_pkg::MSC_ST_BIT_SETUP;
          end
        end
        msc_pkg::MSC_ST_BIT_SETUP: begin
          sin_r <= tx_r[31];
          if (timer_r != 8'h00) begin
            timer_r <= timer_r - 8'h01;
          end else begin
            timer_r <= HALF_LD;
            sclk_r  <= 1'b0;
            st_r    <= msc_pkg::MSC_ST_BIT_LOW;
          end
        end
        msc_pkg::MSC_ST_BIT_LOW: begin
          if (timer_r != 8'h00) begin
            timer_r <= timer_r - 8'h01;
          end else begin
            timer_r <= HALF_LD;
            sclk_r  <= 1'b1;
            tx_r    <= {tx_r[30:0], 1'b0};
            st_r    <= msc_pkg::MSC_ST_BIT_HIGH;
          end
        end
        msc_pkg::MSC_ST_BIT_HIGH: begin
          if (timer_r != 8'h00) begin
            timer_r <= timer_r - 8'h01;
          end else begin
            timer_r <= HALF_LD;
            // sample after the pulse
            // a full half period after the rising edge covers the module's
            // synchroniser plus ours
            if (op_r == msc_pkg::MSC_OP_READ) begin
              rx_r <= {rx_r[30:0], so_sync_r};
            end
            bits_r <= bits_r - 6'h01;
            if (bits_r != 6'h01) begin
              st_r <= msc_pkg::MSC_ST_BIT_SETUP;
            end else if (op_r == msc_pkg::MSC_OP_SELECT) begin
              csn_r <= 1'b1;
              st_r  <= msc_pkg::MSC_ST_CS_RAISE;
            end else begin
              st_r <= msc_pkg::MSC_ST_DONE;
            end
          end
        end
        msc_pkg::MSC_ST_CS_RAISE: begin
          if (timer_r != 8'h00) begin
            timer_r <= timer_r - 8'h01;
          end else begin
            st_r <= msc_pkg::MSC_ST_DONE;
          end
        end
        msc_pkg::MSC_ST_DONE: begin
          rsp_r <= 1'b1;
          st_r  <= msc_pkg::MSC_ST_IDLE;
        end
        default: begin
          st_r <= msc_pkg::MSC_ST_IDLE;
        end
      endcase
    end
  end

  // scan clock pulse: high one half period, low one half period plus one system clock
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      scan_cnt_r <= 9'h000;
      scan_r     <= 1'b0;
    end else if (scan_cnt_r != 9'h000) begin
      scan_cnt_r <= scan_cnt_r - 9'h001;
      scan_r     <= (scan_cnt_r > 9'(HALF_CYC + 1));
    end else if (scan_req) begin
      scan_cnt_r <= SCAN_LD;
      scan_r     <= 1'b1;
    end
  end

  assign scan_ready               = (scan_cnt_r == 9'h000);
  assign rsp_valid                = rsp_r;
  assign rsp_data                 = rx_r;
  assign link.serial_in_line      = sin_r;
  assign link.data_addr_indicator = dai_r;
  assign link.chassis_ctrl_select_n = csn_r;
  assign link.serial_shift_clock  = sclk_r;
  assign link.scan_step_clock     = scan_r;

endmodule // msc_host_end

// >>> msc_link_checker.sv
/*
  link checker: timing relations on the serial link between the host
  end and the module end.
  assumes it is placed beside the link interface, on the system clock.
*/
`timescale 1ns/1ps
module msc_link_checker (
  input wire logic clock,
  input wire logic rst,
  input wire logic serial_in_line,
  input wire logic serial_out_line,
  input wire logic data_addr_indicator,
  input wire logic chassis_ctrl_select_n,
  input wire logic serial_shift_clock,
  input wire logic scan_step_clock
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  logic       sclk_q_r;      // serial clock one cycle ago
  logic [3:0] since_rise_r;  // cycles since the serial clock rose

  // serial clock history for rise detection
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sclk_q_r <= 1'b1;
    end else begin
      sclk_q_r <= serial_shift_clock;
    end
  end

  // saturating count, so an old rise never looks recent
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      since_rise_r <= 4'hF;
    end else if (serial_shift_clock && !sclk_q_r) begin
      since_rise_r <= 4'h1;
    end else if (since_rise_r != 4'hF) begin
      since_rise_r <= since_rise_r + 4'h1;
    end
  end

  property p_csn_edge_sclk_high;
    ($fell(chassis_ctrl_select_n) || $rose(chassis_ctrl_select_n))
      |-> serial_shift_clock && $past(serial_shift_clock);
  endproperty
  property p_sin_change_sclk_high;
    $changed(serial_in_line) |-> serial_shift_clock;
  endproperty
  property p_sclk_low_hold;
    $fell(serial_shift_clock) |-> !serial_shift_clock [*8];
  endproperty
  property p_dai_change_sclk_high;
    $changed(data_addr_indicator) |-> serial_shift_clock && $past(serial_shift_clock);
  endproperty
  property p_out_after_rise;
    $changed(serial_out_line) && chassis_ctrl_select_n && $past(chassis_ctrl_select_n, 8)
      |-> since_rise_r >= 4'h2 && since_rise_r <= 4'h6;
  endproperty
  property p_out_zero_deselect;
    $fell(chassis_ctrl_select_n) |-> ##[1:6] !serial_out_line;
  endproperty
  property p_scan_high_hold;
    $rose(scan_step_clock) |-> scan_step_clock [*6] ##[1:4] !scan_step_clock;
  endproperty
  property p_sclk_quiet_after_csn;
    $rose(chassis_ctrl_select_n) |-> serial_shift_clock [*4];
  endproperty

  a_csn_edge_sclk_high: assert property (p_csn_edge_sclk_high)
    else $error("select moved while serial clock low");
  a_sin_change_sclk_high: assert property (p_sin_change_sclk_high)
    else $error("serial input moved while serial clock low");
  a_sclk_low_hold: assert property (p_sclk_low_hold)
    else $error("serial clock low phase too short");
  a_dai_change_sclk_high: assert property (p_dai_change_sclk_high)
    else $error("indicator moved inside a clock pulse");
  a_out_after_rise: assert property (p_out_after_rise)
    else $error("serial output moved away from a clock rise");
  a_out_zero_deselect: assert property (p_out_zero_deselect)
    else $error("serial output not cleared on deselect");
  a_scan_high_hold: assert property (p_scan_high_hold)
    else $error("scan pulse width wrong");
  a_sclk_quiet_after_csn: assert property (p_sclk_quiet_after_csn)
    else $error("serial clock moved right after select");

  c_select_raise: cover property ($rose(chassis_ctrl_select_n));
  c_out_bit: cover property ($changed(serial_out_line) && chassis_ctrl_select_n);
  c_scan_pulse: cover property ($rose(scan_step_clock));
endmodule // msc_link_checker

// >>> testbench.sv
/*
  testbench: host end and module end joined by the link; commands go in
  at the host, results are compared at both user sides.
  assumes the design files and the link checker are compiled first.
*/
`timescale 1ns/1ps
`include "msc_cfg.svh"
`define CHK(got, exp, msg) \
  begin \
    samples_checked++; \
    if ((got) !== (exp)) begin \
      num_errors++; \
      $display("[FAIL] %0t ns: %s got %0h expected %0h", $time, msg, got, exp); \
    end \
  end

module testbench;
  localparam logic [15:0] TB_SEL = 16'h00B3;       // slot this module answers to
  localparam logic [31:0] TB_ID  = 32'h5E1E_C7ED;  // arbitrary value

  logic                 clock = 1'b0;  // 40 MHz system clock
  logic                 rst;           // async reset, active high
  logic                 cmd_valid;     // command request
  logic                 cmd_ready;     // host idle
  msc_pkg::msc_op_t     cmd_op;        // command code
  logic [31:0]          cmd_data;      // command operand
  logic                 rsp_valid;     // command finished
  logic [31:0]          rsp_data;      // read result
  logic                 scan_req;      // scan pulse request
  logic                 scan_ready;    // no scan pulse running
  logic                 mod_sel;       // module selected
  logic [15:0]          cfg_val;       // configuration register
  logic [3:0]           chan_cnt;      // channel step counter
  int                   num_errors;    // mismatches
  int                   samples_checked;  // comparisons
  logic [15:0]          v;             // value under test
  int                   n;             // random count
  // select codes: idle, ours, first bit flipped, last bit flipped, random
  logic [15:0] n_codes [5] = '{16'h0000, TB_SEL, TB_SEL ^ 16'h8000, TB_SEL ^ 16'h0001,
                               16'h0000};

  msc_link_if link ();

  msc_host_end u_msc_host_end (
    .clock(clock), .rst(rst), .link(link.host_end), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_data(cmd_data), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .scan_req(scan_req), .scan_ready(scan_ready));

  msc_module_end #(.SELECT_CODE(TB_SEL), .MODULE_ID(TB_ID)) u_msc_module_end (
    .clock(clock), .rst(rst), .link(link.module_end), .module_selected(mod_sel),
    .config_value(cfg_val), .channel_step_counter(chan_cnt));

  msc_link_checker u_msc_link_checker (
    .clock(clock), .rst(rst), .serial_in_line(link.serial_in_line),
    .serial_out_line(link.serial_out_line), .data_addr_indicator(link.data_addr_indicator),
    .chassis_ctrl_select_n(link.chassis_ctrl_select_n),
    .serial_shift_clock(link.serial_shift_clock), .scan_step_clock(link.scan_step_clock));

  // free-running clock, 25 ns period
  always #12.5 clock = ~clock;

  // expected selection: whole slot number must match
  function automatic logic exp_sel(input logic [15:0] code);
    return (code == TB_SEL);
  endfunction

  // expected channel after n scan pulses, wrapping after the sensor
  function automatic logic [3:0] exp_chan(input int cnt);
    return 4'(cnt % (int'(`MSC_CHAN_LAST) + 1));
  endfunction

  // one command: waits idle, one-cycle request, bounded wait for answer
  task automatic run_cmd(input msc_pkg::msc_op_t op, input logic [31:0] data);
    int k;
    k = 0;
    while (cmd_ready !== 1'b1 && k < 100) begin
      @(negedge clock);
      k++;
    end
    cmd_op = op;
    cmd_data = data;
    cmd_valid = 1'b1;
    @(negedge clock);
    cmd_valid = 1'b0;
    k = 0;
    while (rsp_valid !== 1'b1 && k < 2000) begin
      @(negedge clock);
      k++;
    end
    if (k >= 2000) begin
      num_errors++;
      $display("[FAIL] %0t ns: no response", $time);
      give_verdict();
    end
  endtask

  // one scan pulse, then wait until the host is ready again
  task automatic scan_once();
    int k;
    scan_req = 1'b1;
    @(negedge clock);
    scan_req = 1'b0;
    k = 0;
    while (scan_ready !== 1'b1 && k < 100) begin
      @(negedge clock);
      k++;
    end
    repeat (4) @(negedge clock);
    if (k >= 100) begin
      num_errors++;
      $display("[FAIL] %0t ns: scan stuck", $time);
      give_verdict();
    end
  endtask

  // prints counts and verdict, ends the run
  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // hang guard: the whole sequence needs about 9000 cycles
  initial begin
    #(40000 * 25);
    num_errors++;
    $display("[FAIL] %0t ns: watchdog expired", $time);
    give_verdict();
  end

  // main sequence
  initial begin
    rst = 1'b1;
    cmd_valid = 1'b0;
    cmd_op = msc_pkg::MSC_OP_SELECT;
    cmd_data = 32'h0000_0000;
    scan_req = 1'b0;
    num_errors = 0;
    samples_checked = 0;
    repeat (3) @(posedge clock);
    @(negedge clock);
    rst = 1'b0;
    void'($urandom(51));
    `CHK(mod_sel, 1'b0, "reset select")
    `CHK(cfg_val, 16'h0000, "reset config")
    `CHK(chan_cnt, 4'h0, "reset counter")
    $display("test reset done");
    // codes differing only in first or last bit catch bit order
    foreach (n_codes[i]) begin
      v = (i == 4) ? 16'($urandom) | 16'h0100 : n_codes[i];
      run_cmd(msc_pkg::MSC_OP_SELECT, {16'h0000, v});
      `CHK(mod_sel, exp_sel(v), "slot select")
    end
    $display("test select done");
    run_cmd(msc_pkg::MSC_OP_SELECT, {16'h0000, TB_SEL});
    for (int i = 0; i < 5; i++) begin
      v = (i == 0) ? 16'h830F : 16'($urandom);
      run_cmd(msc_pkg::MSC_OP_WRITE, {16'h0000, v});
      `CHK(cfg_val, v, "config write")
    end
    run_cmd(msc_pkg::MSC_OP_SELECT, {16'h0000, TB_SEL ^ 16'h0001});
    run_cmd(msc_pkg::MSC_OP_WRITE, {16'h0000, ~v});
    `CHK(cfg_val, v, "write to other slot")
    $display("test write done");
    run_cmd(msc_pkg::MSC_OP_SELECT, {16'h0000, TB_SEL});
    run_cmd(msc_pkg::MSC_OP_READ, 32'h0000_0000);
    `CHK(rsp_data, TB_ID, "id read")
    run_cmd(msc_pkg::MSC_OP_READ, 32'h0000_0000);
    `CHK(rsp_data, 32'h0000_0000, "id past end")
    `CHK(cfg_val, v, "config kept by read")
    run_cmd(msc_pkg::MSC_OP_END, 32'h0000_0000);
    `CHK(mod_sel, 1'b0, "session end")
    run_cmd(msc_pkg::MSC_OP_SELECT, {16'h0000, TB_SEL});
    run_cmd(msc_pkg::MSC_OP_READ, 32'h0000_0000);
    `CHK(rsp_data, TB_ID, "id reloaded")
    run_cmd(msc_pkg::MSC_OP_SELECT, 32'h0000_0000);
    `CHK(mod_sel, 1'b0, "idle slot zero")
    $display("test read done");
    n = 9 + int'($urandom_range(0, 9));
    for (int i = 1; i <= n; i++) begin
      scan_once();
      if (i == 8) begin
        `CHK(chan_cnt, 4'h8, "sensor step")
      end
    end
    `CHK(chan_cnt, exp_chan(n), "channel count")
    $display("test scan done");
    give_verdict();
  end

endmodule // testbench
